// file: pkg/ccrd_map.vh
// Constants for the column clock and reset distribution block
`ifndef CCRD_MAP_VH
`define CCRD_MAP_VH

// =============================================================
// Selector source codes (clock and reset alike)
`define CCRD_SEL_W          2
`define CCRD_SEL_GLOBAL     2'h0
`define CCRD_SEL_EXPRESS    2'h1
`define CCRD_SEL_CELL       2'h2
`define CCRD_SEL_OFF        2'h3

// =============================================================
// Reset values of the selector storage
`define CCRD_CLK_SEL_RST    2'h3
`define CCRD_RST_SEL_RST    2'h0

// =============================================================
// Timing
`define CCRD_CLK_PERIOD_NS  50
`define CCRD_PWRUP_NS       1000
`define CCRD_PWRUP_CYC      ((`CCRD_PWRUP_NS + `CCRD_CLK_PERIOD_NS - 1) / `CCRD_CLK_PERIOD_NS)

`endif

// file: verilog/ccrd_sel4.v
// Four-way source selector with a constant-one input
`timescale 1ns/1ps
`default_nettype none
`include "ccrd_map.vh"

module ccrd_sel4 (
  input  wire       src_global_i,
  input  wire       src_express_i,
  input  wire       src_cell_i,
  input  wire [1:0] sel_i,
  output reg        out_o
);

  // =============================================================
  // Source mux
  always @* begin
    case (sel_i)
      `CCRD_SEL_GLOBAL:  out_o = src_global_i;
      `CCRD_SEL_EXPRESS: out_o = src_express_i;
      `CCRD_SEL_CELL:    out_o = src_cell_i;
      default:           out_o = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/ccrd_cfg_store.v
// Per-column selector storage, one two-bit field per column
`timescale 1ns/1ps
`default_nettype none
`include "ccrd_map.vh"

module ccrd_cfg_store #(
  parameter       NCOL  = 8,
  parameter       IDX_W = 3,
  parameter [1:0] RST_V = 2'h0
) (
  input  wire                clk_sys_i,
  input  wire                arst_n_i,
  input  wire                we_i,
  input  wire [IDX_W-1:0]    idx_i,
  input  wire [1:0]          din_i,
  output wire [2*NCOL-1:0]   q_o
);

  reg [1:0] field_reg [0:NCOL-1];
  integer   k;
  genvar    g;

  // =============================================================
  // Storage, written only by the owning column index
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (k = 0; k < NCOL; k = k + 1) begin
        field_reg[k] <= RST_V;
      end
    end else if (we_i) begin
      field_reg[idx_i] <= din_i;
    end
  end

  generate
    for (g = 0; g < NCOL; g = g + 1) begin : g_flat
      assign q_o[2*g+1:2*g] = field_reg[g];
    end
  endgenerate

endmodule
`default_nettype wire

// file: verilog/ccrd_top.v
// Column clock and asynchronous reset distribution, top level
//
// Notes on behaviour
// - Per-column clock selector, four sources
// - Column clock selections are independent
// - Constant one stops that column's clock
// - Global clock feeds upper corner inputs
// - Express bus shares a secondary clock
// - Column reset acts without the clock
// - Per-column reset selector, four sources
// - Column reset selections are independent
// - Constant one means column reset only by power-up clear
// - Global reset feeds lower corner inputs
// - Express bus shares a secondary reset
// - Power-up clears every cell register
`timescale 1ns/1ps
`default_nettype none
`include "ccrd_map.vh"

module ccrd_top #(
  parameter NCOL  = 8,
  parameter IDX_W = 3,
  parameter CNT_W = 8
) (
  input  wire              clk_sys_i,
  input  wire              arst_n_i,
  input  wire              glb_clk_pin_i,
  input  wire              glb_rst_n_pin_i,
  input  wire [NCOL-1:0]   express_top_i,
  input  wire [NCOL-1:0]   express_bot_i,
  input  wire [NCOL-1:0]   head_cell_a_i,
  input  wire [NCOL-1:0]   foot_cell_a_i,
  input  wire              array_run_i,
  input  wire              cfg_wr_i,
  input  wire [IDX_W-1:0]  cfg_col_i,
  input  wire [1:0]        cfg_clk_sel_i,
  input  wire [1:0]        cfg_rst_sel_i,
  input  wire [IDX_W-1:0]  cfg_rd_col_i,
  output wire [NCOL-1:0]   col_clk_o,
  output wire [NCOL-1:0]   col_rst_n_o,
  output wire              upper_left_corner_clock_input_o,
  output wire              upper_right_corner_clock_input_o,
  output wire              lower_left_corner_reset_input_o,
  output wire              lower_right_corner_reset_input_o,
  output reg  [1:0]        cfg_rd_clk_sel_o,
  output reg  [1:0]        cfg_rd_rst_sel_o,
  output reg               cfg_wr_err_o,
  output reg  [NCOL-1:0]   col_clk_off_o,
  output reg  [NCOL-1:0]   col_rst_off_o,
  output wire              pwrup_busy_o
);

  localparam integer     PWRUP_LAST_I = `CCRD_PWRUP_CYC - 1;
  localparam [CNT_W-1:0] PWRUP_LAST   = PWRUP_LAST_I[CNT_W-1:0];

  wire [2*NCOL-1:0] clk_sel_flat;
  wire [2*NCOL-1:0] rst_sel_flat;
  wire [NCOL-1:0]   col_rst_sel_n;
  wire              cfg_ok;
  wire              pwrup_hold;
  reg               pwrup_busy_reg;
  reg  [CNT_W-1:0]  pwrup_cnt_reg;
  reg  [CNT_W-1:0]  pwrup_cnt_next;
  reg  [NCOL-1:0]   clk_off_next;
  reg  [NCOL-1:0]   rst_off_next;
  integer           c;
  genvar            g;

  // =============================================================
  // Helpers
  function col_valid;
    input [IDX_W-1:0] idx;
    begin
      col_valid = ({1'b0, idx} < NCOL);
    end
  endfunction

  function [1:0] field_at;
    input [2*NCOL-1:0] flat;
    input [IDX_W-1:0]  idx;
    integer j;
    begin
      field_at = 2'h0;
      for (j = 0; j < NCOL; j = j + 1) begin
        if (idx == j[IDX_W-1:0]) begin
          field_at = flat[2*j+1 -: 2];
        end
      end
    end
  endfunction

  // =============================================================
  // Configuration storage, locked while the array runs
  assign cfg_ok = cfg_wr_i && !array_run_i && col_valid(cfg_col_i);

  ccrd_cfg_store #(
    .NCOL  (NCOL),
    .IDX_W (IDX_W),
    .RST_V (`CCRD_CLK_SEL_RST)
  ) u_clk_store (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .we_i      (cfg_ok),
    .idx_i     (cfg_col_i),
    .din_i     (cfg_clk_sel_i),
    .q_o       (clk_sel_flat)
  );

  ccrd_cfg_store #(
    .NCOL  (NCOL),
    .IDX_W (IDX_W),
    .RST_V (`CCRD_RST_SEL_RST)
  ) u_rst_store (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .we_i      (cfg_ok),
    .idx_i     (cfg_col_i),
    .din_i     (cfg_rst_sel_i),
    .q_o       (rst_sel_flat)
  );

  // =============================================================
  // Power-up clear stretch
  always @* begin
    pwrup_cnt_next = pwrup_cnt_reg;
    if (pwrup_busy_reg) begin
      pwrup_cnt_next = pwrup_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwrup_cnt_reg  <= {CNT_W{1'b0}};
      pwrup_busy_reg <= 1'b1;
    end else begin
      pwrup_cnt_reg <= pwrup_cnt_next;
      if (pwrup_busy_reg && (pwrup_cnt_reg == PWRUP_LAST)) begin
        pwrup_busy_reg <= 1'b0;
      end
    end
  end

  assign pwrup_hold   = !arst_n_i || pwrup_busy_reg;
  assign pwrup_busy_o = pwrup_hold;

  // =============================================================
  // Column selectors
  generate
    for (g = 0; g < NCOL; g = g + 1) begin : g_col
      // Own selector per column, express bus as second clock
      ccrd_sel4 u_clk_sel (
        .src_global_i  (glb_clk_pin_i),
        .src_express_i (express_top_i[g]),
        .src_cell_i    (head_cell_a_i[g]),
        .sel_i         (clk_sel_flat[2*g+1:2*g]),
        .out_o         (col_clk_o[g])
      );

      // Own reset selector per column
      ccrd_sel4 u_rst_sel (
        .src_global_i  (glb_rst_n_pin_i),
        .src_express_i (express_bot_i[g]),
        .src_cell_i    (foot_cell_a_i[g]),
        .sel_i         (rst_sel_flat[2*g+1:2*g]),
        .out_o         (col_rst_sel_n[g])
      );

      // Unclocked path, power-up clear overrides
      assign col_rst_n_o[g] = col_rst_sel_n[g] && !pwrup_hold;
    end
  endgenerate

  // =============================================================
  // Corner cell feeds
  assign upper_left_corner_clock_input_o  = glb_clk_pin_i;
  assign upper_right_corner_clock_input_o = glb_clk_pin_i;
  assign lower_left_corner_reset_input_o  = glb_rst_n_pin_i;
  assign lower_right_corner_reset_input_o = glb_rst_n_pin_i;

  // =============================================================
  // Status and readback
  always @* begin
    clk_off_next = {NCOL{1'b0}};
    rst_off_next = {NCOL{1'b0}};
    for (c = 0; c < NCOL; c = c + 1) begin
      clk_off_next[c] = (clk_sel_flat[2*c+1 -: 2] == `CCRD_SEL_OFF);
      rst_off_next[c] = (rst_sel_flat[2*c+1 -: 2] == `CCRD_SEL_OFF);
    end
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_rd_clk_sel_o <= `CCRD_CLK_SEL_RST;
      cfg_rd_rst_sel_o <= `CCRD_RST_SEL_RST;
      cfg_wr_err_o     <= 1'b0;
      col_clk_off_o    <= {NCOL{1'b0}};
      col_rst_off_o    <= {NCOL{1'b0}};
    end else begin
      cfg_rd_clk_sel_o <= field_at(clk_sel_flat, cfg_rd_col_i);
      cfg_rd_rst_sel_o <= field_at(rst_sel_flat, cfg_rd_col_i);
      cfg_wr_err_o     <= cfg_wr_i && !cfg_ok;
      col_clk_off_o    <= clk_off_next;
      col_rst_off_o    <= rst_off_next;
    end
  end

endmodule
`default_nettype wire

// file: sim/ccrd_pin_model.sv
// Global and secondary clock pins around the column distribution
`timescale 1ns/1ps
`default_nettype none
module ccrd_pin_model (
  output logic clk_o,
  output logic sec_clk_o
);
  initial clk_o = 1'b0;
  initial sec_clk_o = 1'b0;
  always #35 clk_o = ~clk_o;
  always #45 sec_clk_o = ~sec_clk_o;
endmodule
`default_nettype wire

// file: sim/ccrd_top_props.sv
// Port assertions of the column distribution block
`timescale 1ns/1ps
`default_nettype none
module ccrd_top_props #(
  parameter NCOL  = 8,
  parameter IDX_W = 3
) (
  input wire logic             clk_sys_i,
  input wire logic             arst_n_i,
  input wire logic             glb_clk_pin_i,
  input wire logic             glb_rst_n_pin_i,
  input wire logic             array_run_i,
  input wire logic             cfg_wr_i,
  input wire logic [IDX_W-1:0] cfg_col_i,
  input wire logic [1:0]       cfg_clk_sel_i,
  input wire logic [NCOL-1:0]  col_clk_o,
  input wire logic [NCOL-1:0]  col_rst_n_o,
  input wire logic [NCOL-1:0]  col_clk_off_o,
  input wire logic             upper_left_corner_clock_input_o,
  input wire logic             upper_right_corner_clock_input_o,
  input wire logic             lower_left_corner_reset_input_o,
  input wire logic             lower_right_corner_reset_input_o,
  input wire logic             cfg_wr_err_o,
  input wire logic             pwrup_busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  AST_CORNER_CLK:
    assert property ({upper_left_corner_clock_input_o, upper_right_corner_clock_input_o}
      == {2{glb_clk_pin_i}}) else $error("corner clock wrong");
  AST_CORNER_RST:
    assert property ({lower_left_corner_reset_input_o, lower_right_corner_reset_input_o}
      == {2{glb_rst_n_pin_i}}) else $error("corner reset wrong");
  AST_CLK_OFF:
    assert property (!$past(cfg_wr_i) |-> (col_clk_o & col_clk_off_o) == col_clk_off_o)
    else $error("stopped column clock moved");
  AST_PWR_HOLD:
    assert property (pwrup_busy_o |-> col_rst_n_o == '0) else $error("reset released early");
  AST_PWR_LEN:
    assert property ($rose(arst_n_i) |-> pwrup_busy_o [*8] ##12 pwrup_busy_o ##1 !pwrup_busy_o)
    else $error("power-up stretch length wrong");
  AST_RUN_REFUSE:
    assert property (cfg_wr_i && array_run_i |=> cfg_wr_err_o) else $error("write while running");
  AST_IDX_REFUSE:
    assert property (cfg_wr_i && cfg_col_i >= NCOL |=> cfg_wr_err_o) else $error("bad index taken");
  AST_WR_OK:
    assert property (cfg_wr_i && !array_run_i && cfg_col_i < NCOL |=> !cfg_wr_err_o ##1
      col_clk_off_o[$past(cfg_col_i, 2)] == ($past(cfg_clk_sel_i, 2) == 2'h3))
    else $error("accepted write not applied");
endmodule
bind ccrd_top ccrd_top_props #(.NCOL(NCOL), .IDX_W(IDX_W)) i_ccrd_top_props (.clk_sys_i,
  .arst_n_i, .glb_clk_pin_i, .glb_rst_n_pin_i, .array_run_i, .cfg_wr_i, .cfg_col_i,
  .cfg_clk_sel_i, .col_clk_o, .col_rst_n_o, .col_clk_off_o, .upper_left_corner_clock_input_o,
  .upper_right_corner_clock_input_o, .lower_left_corner_reset_input_o,
  .lower_right_corner_reset_input_o, .cfg_wr_err_o, .pwrup_busy_o);
`default_nettype wire

// file: sim/test_ccrd_top.sv
// Self-checking bench for the column distribution block
`timescale 1ns/1ps
`default_nettype none
`include "ccrd_map.vh"
module test_ccrd_top;
  localparam N = 6;
  logic        clk_sys_i, arst_n_i, run, wr, rst_req;
  logic [2:0]  col, rd_col;
  logic [1:0]  cs_in, rs_in;
  logic [5:0]  pat;
  logic [11:0] cs, rs;
  wire         gclk, sclk, err, busy;
  wire  [5:0]  cclk, crst, coff, roff;
  wire  [3:0]  corner;
  wire  [1:0]  rd_cs, rd_rs;
  int          error_cnt, n_compared;
  ccrd_pin_model i_ccrd_pin_model (.clk_o(gclk), .sec_clk_o(sclk));
  ccrd_top #(.NCOL(N), .IDX_W(3)) i_ccrd_top (.clk_sys_i, .arst_n_i, .glb_clk_pin_i(gclk),
    .glb_rst_n_pin_i(~rst_req), .express_top_i({N{sclk}}), .express_bot_i(~pat),
    .head_cell_a_i(pat), .foot_cell_a_i(pat ^ 6'h15), .array_run_i(run), .cfg_wr_i(wr),
    .cfg_col_i(col), .cfg_clk_sel_i(cs_in), .cfg_rst_sel_i(rs_in), .cfg_rd_col_i(rd_col),
    .col_clk_o(cclk), .col_rst_n_o(crst), .upper_left_corner_clock_input_o(corner[0]),
    .upper_right_corner_clock_input_o(corner[1]), .lower_left_corner_reset_input_o(corner[2]),
    .lower_right_corner_reset_input_o(corner[3]), .cfg_rd_clk_sel_o(rd_cs),
    .cfg_rd_rst_sel_o(rd_rs), .cfg_wr_err_o(err), .col_clk_off_o(coff), .col_rst_off_o(roff),
    .pwrup_busy_o(busy));
  // ==========================================
  // Helpers
  function automatic [5:0] mx(input [11:0] s, input [5:0] g, x, c);
    for (int i = 0; i < N; i++) begin
      mx[i] = (s[2*i+:2] == 2'h0) ? g[i] : (s[2*i+:2] == 2'h1) ? x[i] :
              (s[2*i+:2] == 2'h2) ? c[i] : 1'b1;
    end
  endfunction
  task automatic chk(input string nm, input logic [5:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_col(input [2:0] c, input [1:0] a, b, input e);
    @(posedge clk_sys_i) #2;
    {wr, col, cs_in, rs_in} = {1'b1, c, a, b};
    @(posedge clk_sys_i) #2;
    wr = 1'b0;
    chk("wr_err", {5'h0, e}, {5'h0, err});
    if (!e) begin
      cs[2*c+:2] = a;
      rs[2*c+:2] = b;
    end
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_pwrup;
    chk("busy", 6'h1, {5'h0, busy});
    chk("crst", 6'h00, crst);
    chk("cclk", 6'h3F, cclk);
    repeat (`CCRD_PWRUP_CYC - 1) @(posedge clk_sys_i);
    #2 chk("busy", 6'h1, {5'h0, busy});
    @(posedge clk_sys_i) #2;
    chk("busy", 6'h0, {5'h0, busy});
    chk("crst", 6'h3F, crst);
  endtask
  task t_sel;
    for (int i = 0; i < N; i++) wr_col(i[2:0], i[1:0], 2'(i + 2), 1'b0);
    @(posedge clk_sys_i) #2;
    chk("coff", 6'h08, coff);
    chk("roff", 6'h22, roff);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys_i) #2;
      {rst_req, pat} = {~k[0], 6'(k * 11)};
      #10 chk("cclk", mx(cs, {N{gclk}}, {N{sclk}}, pat), cclk);
      chk("crst", mx(rs, {N{~rst_req}}, ~pat, pat ^ 6'h15), crst);
      chk("corner", {2'h0, {2{~rst_req}}, {2{gclk}}}, {2'h0, corner});
    end
  endtask
  task t_refuse;
    @(posedge clk_sys_i) #2 run = 1'b1;
    wr_col(3'h0, 2'h3, 2'h3, 1'b1);
    run = 1'b0;
    wr_col(3'h7, 2'h0, 2'h0, 1'b1);
    rd_col = 3'h0;
    repeat (2) @(posedge clk_sys_i);
    #2 chk("rd", {2'h0, cs[1:0], rs[1:0]}, {2'h0, rd_cs, rd_rs});
  endtask
  task t_rearm;
    @(posedge clk_sys_i) #2 arst_n_i = 1'b0;
    {cs, rs} = {12'hFFF, 12'h000};
    #1 chk("busy", 6'h1, {5'h0, busy});
    chk("crst", 6'h00, crst);
    chk("cclk", mx(cs, {N{gclk}}, {N{sclk}}, pat), cclk);
    repeat (2) @(posedge clk_sys_i);
    #2 arst_n_i = 1'b1;
    repeat (`CCRD_PWRUP_CYC) @(posedge clk_sys_i);
    #2 chk("busy", 6'h0, {5'h0, busy});
    chk("crst", mx(rs, {N{~rst_req}}, ~pat, pat ^ 6'h15), crst);
    chk("rd", {2'h0, cs[1:0], rs[1:0]}, {2'h0, rd_cs, rd_rs});
  endtask
  // ==========================================
  // Clock, watchdog, main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {arst_n_i, run, wr, rst_req, col, rd_col, cs_in, rs_in, pat} = '0;
    {cs, rs} = {12'hFFF, 12'h000};
    repeat (4) @(posedge clk_sys_i);
    #2 arst_n_i = 1'b1;
    t_pwrup;
    t_sel;
    t_refuse;
    t_rearm;
    report_and_stop;
  end
endmodule
`default_nettype wire
